// [rtl/fbwp_top.sv]
// serial flash write-protection front end, device side
//
// Operation
// R01 - volatile read-param and bank writes C0h/17h work without write enable
// R02 - program or erase into the protected area is refused
// R03 - whole-array erase only when all four level bits are zero
// R04 - status write disable clear: status write always allowed
// R05 - disable set and protect pin low: status bits read-only, write ignored
// R06 - disable set and protect pin high: status write still accepted
// R07 - quad enable clear: protect and hold pins keep control duties
// R08 - quad enable set: those pins are data lines, no protect function
// R09 - host keeps quad enable clear when those pins are tied to supply
// R10 - 64KB blocks: codes 1 to 10 protect 1 to 512 blocks
// R11 - 64KB blocks: codes 11 to 15 protect 768 up to 1024 blocks
// R12 - top/bottom select picks counting from top or from block zero
// R13 - 256KB blocks: codes 1 to 8 double, 9 and above protect all
// R14 - status write sets levels, quad enable and disable bit, reset zero
// R15 - top/bottom select is one-way: bottom can never return to top; here a reset clears it back to top
// R16 - host sends write enable before program, erase, register writes
// R17 - target block from upper address bits checked before starting
// R18 - multi-block erase refused if any block in range is protected
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fbwp_top
  import fbwp_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // serial link pins
  input  wire logic        i_spi_sck,
  input  wire logic        i_spi_cs_b,
  input  wire logic        i_spi_si,
  input  wire logic        i_data_line_two,
  output logic             o_data_line_two,
  output logic             o_data_line_two_oe_b,
  input  wire logic        i_data_line_three,
  output logic             o_data_line_three,
  output logic             o_data_line_three_oe_b,
  // register port
  input  wire logic [2:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [7:0]       o_reg_rdata,
  // array operation requests
  output logic             o_op_start,
  output logic             o_op_inhibit,
  output logic [7:0]       o_op_code,
  output logic [31:0]      o_op_addr,
  // volatile register writes
  output logic             o_vol_write,
  output logic [7:0]       o_vol_code,
  output logic [7:0]       o_vol_data
);
  fbwp_state_t state_q;
  logic [4:0]  meta_q;
  logic [4:0]  sync_q;
  logic        sck_prev_q;
  logic        cs_prev_q;
  logic [39:0] shift_q;
  logic [5:0]  bit_cnt_q;
  logic [7:0]  opcode_q;
  logic        wel_q;
  logic [7:0]  status_q;
  logic        tbs_q;
  logic        big_blk_q;
  logic [1:0]  last_q;
  logic        sck_s;
  logic        cs_b_s;
  logic        si_s;
  logic        wp_s;
  logic        hold_b_s;
  logic [3:0]  bp;
  logic        qe;
  logic        wp_eff;
  logic        hold_act;
  logic        sck_rise;
  logic        frame_end;
  logic        is_addr_cmd;
  logic        is_ce;
  logic        is_status_write_command;
  logic        is_vol_nw;
  logic        is_vol_w;
  logic        exec;
  logic        sr_unlocked;
  logic        hit;
  fbwp_size_t  size_sel;

  // pins enter through two flops before use
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 5'h1A;
      sync_q <= 5'h1A;
    end else begin
      meta_q <= {i_data_line_three, i_data_line_two, i_spi_si, i_spi_cs_b, i_spi_sck};
      sync_q <= meta_q;
    end
  end

  assign sck_s    = sync_q[0];
  assign cs_b_s   = sync_q[1];
  assign si_s     = sync_q[2];
  assign wp_s     = sync_q[3];
  assign hold_b_s = sync_q[4];
  assign bp       = status_q[ST_BP0+3:ST_BP0];
  assign qe       = status_q[ST_QE];
  // with quad lines on, the protect pin carries data and never locks
  assign wp_eff   = qe ? 1'b1 : wp_s; // R08
  assign hold_act = !qe && !hold_b_s; // R07

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_b_s;
    end
  end

  // hold freezes the shifter, edges under hold are dropped
  assign sck_rise  = sck_s && !sck_prev_q && !cs_b_s && !hold_act; // R07
  assign frame_end = cs_b_s && !cs_prev_q;

  // frame state
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  state_q <= (!cs_b_s) ? ST_FRAME : ST_IDLE;
        ST_FRAME: state_q <= frame_end ? ST_EXEC : ST_FRAME;
        ST_EXEC:  state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // bit shifter, count saturates so long frames stay invalid
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_q   <= 40'h00_0000_0000;
      bit_cnt_q <= 6'h00;
      opcode_q  <= 8'h00;
    end else if (state_q == ST_IDLE) begin
      bit_cnt_q <= 6'h00;
    end else if (sck_rise) begin
      shift_q <= {shift_q[38:0], si_s};
      if (bit_cnt_q != 6'h3F) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
      if (bit_cnt_q == LEN_CMD - 6'h01) begin
        opcode_q <= {shift_q[6:0], si_s};
      end
    end
  end

  always_comb begin
    is_addr_cmd = 1'b1;
    size_sel    = SZ_PAGE;
    case (opcode_q)
      OP_PP:            size_sel = SZ_PAGE;
      OP_SE_A, OP_SE_B: size_sel = SZ_4K;
      OP_BE32:          size_sel = SZ_32K;
      OP_BE64:          size_sel = SZ_BLK;
      default:          is_addr_cmd = 1'b0;
    endcase
  end

  assign exec      = (state_q == ST_EXEC);
  assign is_ce     = ((opcode_q == OP_CE_A) || (opcode_q == OP_CE_B)) && (bit_cnt_q == LEN_CMD);
  assign is_status_write_command   = (opcode_q == OP_STATUS_WRITE_COMMAND) && (bit_cnt_q == LEN_BYTE);
  assign is_vol_nw = ((opcode_q == OP_VRP_NW) || (opcode_q == OP_VBR_NW))
                     && (bit_cnt_q == LEN_BYTE);
  assign is_vol_w  = ((opcode_q == OP_VRP) || (opcode_q == OP_VBR)) && (bit_cnt_q == LEN_BYTE);
  assign sr_unlocked = !status_q[ST_SWD] || wp_eff; // R04 R05 R06

  fbwp_prot_check u_prot (
    .i_bp      (bp),
    .i_tbs     (tbs_q),
    .i_big_blk (big_blk_q),
    .i_size    (size_sel),
    .i_addr    (shift_q[31:0]),
    .o_hit     (hit)
  );

  // write enable latch
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wel_q <= 1'b0;
    end else if (exec && (bit_cnt_q == LEN_CMD) && (opcode_q == OP_WRITE_ENABLE_COMMAND)) begin
      wel_q <= 1'b1; // R16
    end else if (exec && (bit_cnt_q == LEN_CMD) && (opcode_q == OP_WRDI)) begin
      wel_q <= 1'b0;
    end else if (exec && (is_status_write_command || is_vol_w || is_ce
                 || (is_addr_cmd && (bit_cnt_q == LEN_ADDR)))) begin
      wel_q <= 1'b0;
    end
  end

  // status bits, writable only while the latch is open and not locked
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_q <= ST_RESET; // R14
    end else if (exec && is_status_write_command && wel_q && sr_unlocked) begin
      status_q <= shift_q[7:0] & ST_WMASK; // R14 R04 R06
    end
  end

  // one-way bottom select and block size option
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tbs_q     <= 1'b0;
      big_blk_q <= 1'b0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == RA_FUNC) begin
        tbs_q <= tbs_q | i_reg_wdata[FN_TBS]; // R15
      end
      if (i_reg_addr == RA_CFG) begin
        big_blk_q <= i_reg_wdata[CFG_BIG];
      end
    end
  end

  // array request decision
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_op_start   <= 1'b0;
      o_op_inhibit <= 1'b0;
      o_op_code    <= 8'h00;
      o_op_addr    <= 32'h0000_0000;
    end else begin
      o_op_start   <= 1'b0;
      o_op_inhibit <= 1'b0;
      if (exec && wel_q && is_addr_cmd && (bit_cnt_q == LEN_ADDR)) begin
        o_op_code    <= opcode_q;
        o_op_addr    <= shift_q[31:0];
        o_op_start   <= !hit; // R17
        o_op_inhibit <= hit; // R02 R18
      end else if (exec && wel_q && is_ce) begin
        o_op_code    <= opcode_q;
        o_op_addr    <= 32'h0000_0000;
        o_op_start   <= (bp == 4'h0); // R03
        o_op_inhibit <= (bp != 4'h0); // R03
      end
    end
  end

  // volatile register writes
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_vol_write <= 1'b0;
      o_vol_code  <= 8'h00;
      o_vol_data  <= 8'h00;
    end else begin
      o_vol_write <= 1'b0;
      if (exec && (is_vol_nw || (is_vol_w && wel_q))) begin
        o_vol_write <= 1'b1; // R01
        o_vol_code  <= opcode_q;
        o_vol_data  <= shift_q[7:0];
      end
    end
  end

  // last decision record for software
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_q <= 2'h0;
    end else if (o_op_start || o_op_inhibit) begin
      last_q <= {o_op_start, o_op_inhibit};
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        RA_STATUS: o_reg_rdata <= status_q | {6'h00, wel_q, 1'b0};
        RA_FUNC:   o_reg_rdata <= {6'h00, tbs_q, 1'b0};
        RA_CFG:    o_reg_rdata <= {7'h00, big_blk_q};
        RA_LAST:   o_reg_rdata <= {6'h00, last_q};
        default:   o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // single-line protocol only, the quad lines are never driven
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data_line_two        <= 1'b0;
      o_data_line_two_oe_b   <= 1'b1;
      o_data_line_three      <= 1'b0;
      o_data_line_three_oe_b <= 1'b1;
    end else begin
      o_data_line_two        <= 1'b0;
      o_data_line_two_oe_b   <= 1'b1;
      o_data_line_three      <= 1'b0;
      o_data_line_three_oe_b <= 1'b1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_sr_write;
    exec && is_status_write_command && wel_q;
  endsequence
  sequence s_addr_exec;
    exec && wel_q && is_addr_cmd && (bit_cnt_q == LEN_ADDR);
  endsequence

  chk_vol_no_wel: assert property ( // R01
    exec && is_vol_nw && !wel_q |=> o_vol_write && (o_vol_data == $past(shift_q[7:0])))
    else $error("volatile write without enable not accepted");
  chk_prot_refuse: assert property ( // R02
    s_addr_exec ##0 hit |=> o_op_inhibit && !o_op_start)
    else $error("protected target not refused");
  chk_prot_start: assert property ( // R17
    s_addr_exec ##0 !hit |=> o_op_start && (o_op_addr == $past(shift_q[31:0])))
    else $error("unprotected target not started");
  chk_ce_levels: assert property ( // R03
    o_op_start && ((o_op_code == OP_CE_A) || (o_op_code == OP_CE_B)) |-> $past(bp) == 4'h0)
    else $error("whole-array erase started with nonzero levels");
  chk_sr_open: assert property ( // R04
    s_sr_write ##0 !status_q[ST_SWD] |=> status_q == ($past(shift_q[7:0]) & ST_WMASK))
    else $error("status write refused while unlocked");
  chk_sr_locked: assert property ( // R05
    s_sr_write ##0 status_q[ST_SWD] && !wp_eff |=> $stable(status_q))
    else $error("locked status changed");
  chk_sr_wp_high: assert property ( // R06
    s_sr_write ##0 status_q[ST_SWD] && wp_s && !qe
    |=> status_q == ($past(shift_q[7:0]) & ST_WMASK))
    else $error("status write refused with protect pin high");
  chk_hold_freeze: assert property ( // R07
    (state_q == ST_FRAME) && hold_act && !frame_end |=> $stable(bit_cnt_q))
    else $error("shifter moved under hold");
  chk_quad_nolock: assert property ( // R08
    s_sr_write ##0 qe |=> status_q == ($past(shift_q[7:0]) & ST_WMASK))
    else $error("protect pin locked status in quad mode");
  chk_tbs_oneway: assert property ( // R15
    tbs_q |=> tbs_q)
    else $error("bottom select returned to top");
endmodule
`default_nettype wire

// [shared/fbwp_pkg.sv]
// constants for the flash block write protection logic
package fbwp_pkg;
  // serial opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_COMMAND   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE_COMMAND   = 8'h01;
  localparam logic [7:0] OP_CE_A   = 8'hC7;
  localparam logic [7:0] OP_CE_B   = 8'h60;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_SE_A   = 8'h20;
  localparam logic [7:0] OP_SE_B   = 8'hD7;
  localparam logic [7:0] OP_BE32   = 8'h52;
  localparam logic [7:0] OP_BE64   = 8'hD8;
  localparam logic [7:0] OP_VRP_NW = 8'hC0;
  localparam logic [7:0] OP_VBR_NW = 8'h17;
  localparam logic [7:0] OP_VRP    = 8'h63;
  localparam logic [7:0] OP_VBR    = 8'hC5;
  // frame lengths in bits
  localparam logic [5:0] LEN_CMD   = 6'h08;
  localparam logic [5:0] LEN_BYTE  = 6'h10;
  localparam logic [5:0] LEN_ADDR  = 6'h28;
  // status byte fields
  localparam int ST_WEL = 1;
  localparam int ST_BP0 = 2;
  localparam int ST_QE  = 6;
  localparam int ST_SWD = 7;
  localparam logic [7:0] ST_WMASK  = 8'hFC;
  localparam logic [7:0] ST_RESET  = 8'h00;
  // register port map
  localparam logic [2:0] RA_STATUS = 3'h0;
  localparam logic [2:0] RA_FUNC   = 3'h1;
  localparam logic [2:0] RA_CFG    = 3'h2;
  localparam logic [2:0] RA_LAST   = 3'h3;
  localparam int FN_TBS  = 1;
  localparam int CFG_BIG = 0;
  // erase or program extent
  typedef enum logic [1:0] {SZ_PAGE, SZ_4K, SZ_32K, SZ_BLK} fbwp_size_t;
  localparam logic [31:0] MSK_PAGE = 32'h0000_00FF;
  localparam logic [31:0] MSK_4K   = 32'h0000_0FFF;
  localparam logic [31:0] MSK_32K  = 32'h0000_7FFF;
  localparam logic [31:0] MSK_64K  = 32'h0000_FFFF;
  localparam logic [31:0] MSK_256K = 32'h0003_FFFF;
  localparam logic [10:0] BLK_64K_N  = 11'h400;
  localparam logic [10:0] BLK_256K_N = 11'h100;
  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_EXEC} fbwp_state_t;
endpackage

// [rtl/fbwp_prot_check.sv]
// protected-range lookup for one program or erase target
`timescale 1ns/1ps
`default_nettype none
module fbwp_prot_check
  import fbwp_pkg::*;
(
  // protection setup
  input  wire logic [3:0]  i_bp,
  input  wire logic        i_tbs,
  input  wire logic        i_big_blk,
  // target
  input  wire fbwp_size_t  i_size,
  input  wire logic [31:0] i_addr,
  // result
  output logic             o_hit
);
  function automatic logic [10:0] prot_count(input logic [3:0] bp, input logic big);
    logic [10:0] c;
    c = 11'h000;
    if (bp == 4'h0) begin
      c = 11'h000;
    end else if (big) begin
      c = (bp <= 4'h8) ? (11'h001 << (bp - 4'h1)) : BLK_256K_N; // R13
    end else if (bp <= 4'hA) begin
      c = 11'h001 << (bp - 4'h1); // R10
    end else if (bp == 4'hF) begin
      c = BLK_64K_N; // R11
    end else begin
      c = BLK_64K_N - (11'h100 >> (bp - 4'hB)); // R11
    end
    return c;
  endfunction

  function automatic logic [10:0] blk_of(input logic [31:0] a, input logic big);
    return big ? {3'h0, a[25:18]} : {1'h0, a[25:16]};
  endfunction

  logic [31:0] mask;
  logic [31:0] lo_a;
  logic [31:0] hi_a;
  logic [10:0] cnt;
  logic [10:0] total;

  always_comb begin
    case (i_size)
      SZ_PAGE: mask = MSK_PAGE;
      SZ_4K:   mask = MSK_4K;
      SZ_32K:  mask = MSK_32K;
      default: mask = i_big_blk ? MSK_256K : MSK_64K;
    endcase
  end

  // whole extent is checked, any protected block inside it blocks all
  assign lo_a  = i_addr & ~mask; // R18
  assign hi_a  = lo_a | mask; // R18
  assign cnt   = prot_count(i_bp, i_big_blk);
  assign total = i_big_blk ? BLK_256K_N : BLK_64K_N;
  assign o_hit = (cnt != 11'h000) &&
                 (i_tbs ? (blk_of(lo_a, i_big_blk) < cnt) // R12
                        : (blk_of(hi_a, i_big_blk) >= (total - cnt))); // R12 R17
endmodule
`default_nettype wire

// [dv/fbwp_host_model.sv]
// host-side serial controller model that frames single-line commands
`timescale 1ns/1ps
`default_nettype none
module fbwp_host_model (
  // serial link
  output logic o_spi_sck,
  output logic o_spi_cs_b,
  output logic o_spi_si
);
  localparam time HALF = 24ns;

  initial begin
    o_spi_sck  = 1'b0;
    o_spi_cs_b = 1'b1;
    o_spi_si   = 1'b0;
  end

  // mode 0: data changes in the low phase, clock parked low between frames
  task automatic send(input logic [39:0] bits, input int len);
    #3;
    o_spi_cs_b = 1'b0;
    for (int i = len - 1; i >= 0; i--) begin
      o_spi_si = bits[i];
      #HALF;
      o_spi_sck = 1'b1;
      #HALF;
      o_spi_sck = 1'b0;
    end
    #HALF;
    o_spi_cs_b = 1'b1;
    // released line must not keep showing the last bit
    o_spi_si = ~o_spi_si;
  endtask
endmodule
`default_nettype wire

// [dv/tb_fbwp_top.sv]
// self-checking bench for the block write-protection front end
`timescale 1ns/1ps
`default_nettype none
module tb_fbwp_top
  import fbwp_pkg::*;
;
  logic        i_sys_clk;
  logic        i_rst_b;
  logic        pin_two;
  logic        pin_three;
  logic [2:0]  i_reg_addr;
  logic [7:0]  i_reg_wdata;
  logic        i_reg_wr;
  logic        i_reg_rd;
  logic [7:0]  o_reg_rdata;
  logic        o_op_start;
  logic        o_op_inhibit;
  logic [7:0]  o_op_code;
  logic [31:0] o_op_addr;
  logic        o_vol_write;
  logic [7:0]  o_vol_code;
  logic [7:0]  o_vol_data;
  logic        two_d;
  logic        two_oe_b;
  logic        three_d;
  logic        three_oe_b;
  wire         sck;
  wire         cs_b;
  wire         si;
  wire         line_two;
  wire         line_three;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  int          cnt64 [16] = '{0, 1, 2, 4, 8, 16, 32, 64, 128, 256, 512, 768, 896, 960, 992, 1024};
  logic [7:0]  ops [5] = '{OP_PP, OP_SE_A, OP_SE_B, OP_BE32, OP_BE64};

  // pins are resolved from every driver; the device never drives in single-line use
  assign line_two   = two_oe_b ? pin_two : two_d;
  assign line_three = three_oe_b ? pin_three : three_d;

  fbwp_host_model u_fbwp_host_model (
    .o_spi_sck (sck),
    .o_spi_cs_b(cs_b),
    .o_spi_si  (si)
  );

  fbwp_top u_fbwp_top (
    .i_sys_clk             (i_sys_clk),
    .i_rst_b               (i_rst_b),
    .i_spi_sck             (sck),
    .i_spi_cs_b            (cs_b),
    .i_spi_si              (si),
    .i_data_line_two       (line_two),
    .o_data_line_two       (two_d),
    .o_data_line_two_oe_b  (two_oe_b),
    .i_data_line_three     (line_three),
    .o_data_line_three     (three_d),
    .o_data_line_three_oe_b(three_oe_b),
    .i_reg_addr            (i_reg_addr),
    .i_reg_wdata           (i_reg_wdata),
    .i_reg_wr              (i_reg_wr),
    .i_reg_rd              (i_reg_rd),
    .o_reg_rdata           (o_reg_rdata),
    .o_op_start            (o_op_start),
    .o_op_inhibit          (o_op_inhibit),
    .o_op_code             (o_op_code),
    .o_op_addr             (o_op_addr),
    .o_vol_write           (o_vol_write),
    .o_vol_code            (o_vol_code),
    .o_vol_data            (o_vol_data)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // whole run needs roughly 60k cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk({24'h0, o_reg_rdata}, {24'h0, exp}, what);
  endtask

  task automatic frame(input logic [39:0] bits, input int len);
    u_fbwp_host_model.send(bits, len);
    repeat (8) @(posedge i_sys_clk);
  endtask

  // kind: 0 started, 1 inhibited, 2 volatile write, 3 nothing
  task automatic issue(input logic [39:0] bits, input int len, input int kind,
                       input logic [7:0] code, input logic [31:0] addr);
    int seen;
    seen = 3;
    u_fbwp_host_model.send(bits, len);
    for (int n = 0; n < 30 && seen == 3; n++) begin
      @(posedge i_sys_clk);
      #1;
      if (o_op_start === 1'b1) seen = 0;
      else if (o_op_inhibit === 1'b1) seen = 1;
      else if (o_vol_write === 1'b1) seen = 2;
    end
    chk(seen, kind, "decision kind");
    if (seen < 2) begin
      chk({24'h0, o_op_code}, {24'h0, code}, "op code");
      chk(o_op_addr, addr, "op address");
    end
    if (seen == 2) begin
      chk({24'h0, o_vol_code}, {24'h0, code}, "volatile code");
      chk({24'h0, o_vol_data}, addr, "volatile data");
    end
    repeat (6) @(posedge i_sys_clk);
  endtask

  task automatic status_write_command(input logic [7:0] b);
    frame(OP_WRITE_ENABLE_COMMAND, 8);
    frame({OP_STATUS_WRITE_COMMAND, b}, 16);
  endtask

  task automatic t_reset();
    reg_rd(RA_STATUS, 8'h00, "status after reset");
    reg_rd(RA_FUNC, 8'h00, "function after reset");
    reg_rd(RA_CFG, 8'h00, "config after reset");
    reg_wr(3'h5, 8'hFF);
    reg_rd(3'h5, 8'h00, "unmapped read");
    reg_wr(RA_STATUS, 8'hFC);
    reg_rd(RA_STATUS, 8'h00, "status is read-only on the port");
    chk({28'h0, two_d, three_d, two_oe_b, three_oe_b}, 32'h3, "pins never driven");
  endtask

  task automatic t_volatile();
    issue({OP_VRP_NW, 8'h5A}, 16, 2, OP_VRP_NW, 32'h5A);
    issue({OP_VBR_NW, 8'hA5}, 16, 2, OP_VBR_NW, 32'hA5);
    issue({OP_VRP, 8'h3C}, 16, 3, 8'h00, 32'h0);
    issue({OP_PP, 32'h0}, 40, 3, 8'h00, 32'h0);
    frame(OP_WRITE_ENABLE_COMMAND, 8);
    frame(OP_WRDI, 8);
    issue({OP_VRP, 8'h3C}, 16, 3, 8'h00, 32'h0);
    // enable sent under hold must be lost, so the next guarded write stays dead
    @(posedge i_sys_clk);
    pin_three <= 1'b0;
    frame(OP_WRITE_ENABLE_COMMAND, 8);
    @(posedge i_sys_clk);
    pin_three <= 1'b1;
    issue({OP_VRP, 8'h3C}, 16, 3, 8'h00, 32'h0);
    frame(OP_WRITE_ENABLE_COMMAND, 8);
    issue({OP_VBR, 8'hC3}, 16, 2, OP_VBR, 32'hC3);
  endtask

  task automatic t_lock();
    @(posedge i_sys_clk);
    pin_two <= 1'b0;
    status_write_command(8'h84);
    reg_rd(RA_STATUS, 8'h84, "write with disable clear");
    status_write_command(8'h00);
    reg_rd(RA_STATUS, 8'h84, "locked write ignored");
    @(posedge i_sys_clk);
    pin_two <= 1'b1;
    status_write_command(8'h00);
    reg_rd(RA_STATUS, 8'h00, "write with pin high");
    status_write_command(8'hC0);
    @(posedge i_sys_clk);
    pin_two <= 1'b0;
    status_write_command(8'h00);
    reg_rd(RA_STATUS, 8'h00, "quad mode ignores protect pin");
    @(posedge i_sys_clk);
    pin_two <= 1'b1;
  endtask

  task automatic t_whole();
    logic [7:0] op;
    for (int i = 0; i < 2; i++) begin
      op = (i == 0) ? OP_CE_A : OP_CE_B;
      status_write_command(8'h04);
      frame(OP_WRITE_ENABLE_COMMAND, 8);
      issue({32'h0, op}, 8, 1, op, 32'h0);
      status_write_command(8'h00);
      frame(OP_WRITE_ENABLE_COMMAND, 8);
      issue({32'h0, op}, 8, 0, op, 32'h0);
    end
  endtask

  // protected edge and the free page beside it (unless all is protected), for level codes 1 to 15 taken at the given step
  task automatic t_levels(input logic big, input logic bottom, input int step);
    int n;
    int total;
    int sh;
    int edge_blk;
    logic [7:0] op;
    logic [31:0] pa;
    logic [31:0] ua;
    reg_wr(RA_CFG, {7'h0, big});
    total = big ? 256 : 1024;
    sh = big ? 18 : 16;
    for (int c = 1; c < 16; c += step) begin
      n = (big && c > 8) ? 256 : cnt64[c];
      edge_blk = bottom ? n : total - n;
      op = ops[c % 5];
      pa = bottom ? (n << sh) - 32'h100 : edge_blk << sh;
      ua = bottom ? (n << sh) : (edge_blk << sh) - 32'h100;
      status_write_command({2'b00, c[3:0], 2'b00});
      frame(OP_WRITE_ENABLE_COMMAND, 8);
      issue({op, pa}, 40, 1, op, pa);
      if (n < total) begin
        frame(OP_WRITE_ENABLE_COMMAND, 8);
        issue({op, ua}, 40, 0, op, ua);
      end
    end
  endtask

  initial begin
    i_rst_b     = 1'b0;
    pin_two     = 1'b1;
    pin_three   = 1'b1;
    i_reg_addr  = 3'h0;
    i_reg_wdata = 8'h00;
    i_reg_wr    = 1'b0;
    i_reg_rd    = 1'b0;
    repeat (6) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    t_reset();
    t_volatile();
    t_lock();
    t_whole();
    t_levels(1'b0, 1'b0, 1);
    t_levels(1'b1, 1'b0, 1);
    reg_wr(RA_FUNC, 8'h02);
    reg_wr(RA_FUNC, 8'h00);
    reg_rd(RA_FUNC, 8'h02, "bottom select stays set");
    t_levels(1'b0, 1'b1, 2);
    t_levels(1'b1, 1'b1, 2);
    reg_rd(RA_LAST, 8'h01, "last decision inhibited");
    stop_test();
  end
endmodule
`default_nettype wire
